// ===== inc/fbdiag_pkg.sv
package fbdiag_pkg;

    // ------------------------------------------------------------
    // Parameter addresses
    // ------------------------------------------------------------
    localparam int PAR_AW = 11;
    localparam logic [10:0] ADDR_SYNC_CYCLE_PERIOD = 11'h3f4;
    localparam logic [10:0] ADDR_LINK_LAYER_STATUS = 11'h3fc;
    localparam logic [10:0] ADDR_APP_LAYER_STATUS = 11'h3fd;
    localparam logic [10:0] ADDR_APP_LAYER_CODE = 11'h3fe;
    localparam logic [10:0] ADDR_CONFIG_MEMORY = 11'h3ff;
    localparam logic [10:0] ADDR_SYNC_OUTPUT_UNIT = 11'h400;
    localparam logic [10:0] ADDR_SYNC_PULSE_LENGTH = 11'h401;
    localparam logic [10:0] ADDR_SYNC_ACTIVATION = 11'h402;
    localparam logic [10:0] ADDR_SYNC0_CYCLE_TIME = 11'h403;
    localparam logic [10:0] ADDR_COMM_ERROR_DETAIL = 11'h42e;
    localparam logic [10:0] ADDR_MISSED_TOLERANCE = 11'h430;
    localparam logic [10:0] ADDR_MAX_CONSEC_LOSS = 11'h431;
    localparam logic [10:0] ADDR_LOST_TOTAL = 11'h432;
    localparam logic [10:0] ADDR_LOST_TOTAL_AUTOCLR = 11'h434;
    localparam logic [10:0] ADDR_SYNC_FRAME_DIFF = 11'h436;
    localparam logic [10:0] ADDR_RX_TOTAL = 11'h438;
    localparam logic [10:0] ADDR_CONSEC_AUTOCLR = 11'h43c;
    localparam logic [10:0] ADDR_ENTRY_COUNT = 11'h43e;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [31:0] RST_SYNC_CYCLE_PERIOD = 32'h0000_0000;
    localparam logic [15:0] RST_MISSED_TOLERANCE = 16'h0001;
    localparam logic [31:0] MAX_SYNC_CYCLE_PERIOD = 32'h0000_7d00;
    localparam logic [15:0] MAX_MISSED_TOLERANCE = 16'h0080;
    localparam logic [7:0] DIAG_ENTRY_COUNT = 8'h0f;
    localparam logic [7:0] DETAIL_CAUSE_MISSED = 8'h01;

    // ------------------------------------------------------------
    // Link state codes
    // ------------------------------------------------------------
    localparam logic [3:0] LINK_INIT = 4'h1;
    localparam logic [3:0] LINK_PREOP = 4'h2;
    localparam logic [3:0] LINK_SAFEOP = 4'h4;
    localparam logic [3:0] LINK_OP = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SYNC_UNIT_NS = 1000;
    localparam int CYC_PER_US = SYNC_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [6:0] US_LAST = 7'(CYC_PER_US - 1);

endpackage

// ===== verilog/fbdiag_mirror.sv
`timescale 1ns/1ps
module fbdiag_mirror
    import fbdiag_pkg::*;
(
    input wire logic mclk, // Drive clock
    input wire logic rst, // Synchronous reset
    input wire logic [15:0] sc_link_status, // Link-layer status
    input wire logic [15:0] sc_app_status, // Application-layer status
    input wire logic [15:0] sc_app_code, // Application-layer status code
    input wire logic [15:0] sc_config_mem, // Configuration-memory control
    input wire logic [15:0] sc_sync_unit, // Sync output unit
    input wire logic [15:0] sc_sync_pulse_len, // Sync pulse length
    input wire logic [15:0] sc_sync_active, // Sync activation status
    input wire logic [31:0] sc_sync0_cycle, // Sync0 cycle time
    output logic [15:0] link_layer_status_mirror, // Copy of link status
    output logic [15:0] app_layer_status_mirror, // Copy of app status
    output logic [15:0] app_layer_status_code_mirror, // Copy of status code
    output logic [15:0] config_memory_mirror, // Copy of config control
    output logic [15:0] sync_output_unit_mirror, // Copy of sync unit
    output logic [15:0] sync_pulse_length_mirror, // Copy of pulse length
    output logic [15:0] sync_activation_mirror, // Copy of activation
    output logic [31:0] sync0_cycle_time_mirror // Copy of sync0 cycle
);

    // ------------------------------------------------------------
    // Mirror state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] link;
        logic [15:0] app;
        logic [15:0] code;
        logic [15:0] cfg;
        logic [15:0] unit;
        logic [15:0] plen;
        logic [15:0] act;
        logic [31:0] cyc;
    } fbdiag_mir_t;

    fbdiag_mir_t mir_q;
    fbdiag_mir_t mir_d;

    // The copies are registered from the controller every cycle, so they lag it by one clock.
    always_comb begin
        mir_d.link = sc_link_status; // [RULE13]
        mir_d.app = sc_app_status; // [RULE14]
        mir_d.code = sc_app_code; // [RULE15] [RULE12]
        mir_d.cfg = sc_config_mem; // [RULE16]
        mir_d.unit = sc_sync_unit; // [RULE17]
        mir_d.plen = sc_sync_pulse_len; // [RULE17]
        mir_d.act = sc_sync_active; // [RULE17]
        mir_d.cyc = sc_sync0_cycle; // [RULE17]
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mir_q <= '0;
        end else begin
            mir_q <= mir_d;
        end
    end

    assign link_layer_status_mirror = mir_q.link;
    assign app_layer_status_mirror = mir_q.app;
    assign app_layer_status_code_mirror = mir_q.code;
    assign config_memory_mirror = mir_q.cfg;
    assign sync_output_unit_mirror = mir_q.unit;
    assign sync_pulse_length_mirror = mir_q.plen;
    assign sync_activation_mirror = mir_q.act;
    assign sync0_cycle_time_mirror = mir_q.cyc;

endmodule

// ===== verilog/fbdiag_top.sv
`timescale 1ns/1ps
// Functional notes
// [RULE1] Cycle period 0..32000 us, default 0, paces soft-timed sync.
// [RULE2] Fault when consecutive missed frames exceed tolerance 0..128, default 1.
// [RULE3] Software should set the tolerance above 4.
// [RULE4] 16-bit longest missed run, reset zero, updated only in operational.
// [RULE5] 32-bit missed-frame counter, reset zero, counts only in operational.
// [RULE6] Signed 32-bit lost total, operational only, cleared entering operational.
// [RULE7] 16-bit consecutive-loss counter, operational only, cleared entering operational.
// [RULE8] Signed sync minus frame difference, operational and hardware sync only.
// [RULE9] 32-bit received-frame counter saturates at maximum until written.
// [RULE10] Received-frame counter accepts any write, clears entering operational.
// [RULE11] Faults only raised while the drive is operation-enabled.
// [RULE12] Status-code mirror always readable.
// [RULE13] Read-only copy of link-layer status.
// [RULE14] Read-only copy of application-layer status.
// [RULE15] Read-only copy of application-layer status code.
// [RULE16] Read-only copy of configuration-memory control.
// [RULE17] Read-only copies of sync unit, pulse length, activation, sync0 cycle.
// [RULE18] Group entry count reads constant 15, not writable.
// [RULE19] Writes replace counter values; counting continues from them.
module fbdiag_top
    import fbdiag_pkg::*;
(
    input wire logic mclk, // Drive clock, 125 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [10:0] par_addr, // Parameter address
    input wire logic par_wr, // Parameter write strobe
    input wire logic [31:0] par_wdata, // Parameter write data
    input wire logic par_rd, // Parameter read strobe
    output logic [31:0] par_rdata, // Parameter read data
    output logic par_rvalid, // Read data valid pulse
    input wire logic [3:0] link_state, // Link state machine code
    input wire logic hardware_timed_sync, // Hardware-timed sync selected
    input wire logic drive_op_enabled, // Drive in operation-enabled state
    input wire logic pdo_rx_ok, // Receive frame taken in correctly
    input wire logic pdo_rx_lost, // Receive frame missed
    input wire logic sync_pulse, // Sync pulse detected
    input wire logic [15:0] sc_link_status, // Controller link-layer status
    input wire logic [15:0] sc_app_status, // Controller app-layer status
    input wire logic [15:0] sc_app_code, // Controller app-layer status code
    input wire logic [15:0] sc_config_mem, // Controller config-memory control
    input wire logic [15:0] sc_sync_unit, // Controller sync output unit
    input wire logic [15:0] sc_sync_pulse_len, // Controller sync pulse length
    input wire logic [15:0] sc_sync_active, // Controller sync activation
    input wire logic [31:0] sc_sync0_cycle, // Controller sync0 cycle time
    output logic comm_fault, // Communication fault level
    output logic soft_sync_tick // Software-timed sync pulse
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] rdata;
        logic rvalid;
        logic [31:0] period;
        logic [15:0] tol;
        logic [15:0] max_consec;
        logic [31:0] lost_total;
        logic signed [31:0] lost_ac;
        logic signed [31:0] diff;
        logic [31:0] rx_total;
        logic [15:0] consec;
        logic fault;
        logic [31:0] detail;
        logic [3:0] prev_state;
        logic [6:0] us_cnt;
        logic [31:0] tick_cnt;
        logic tick;
    } fbdiag_st_t;

    fbdiag_st_t st_q;
    fbdiag_st_t st_d;

    logic [15:0] mir_link;
    logic [15:0] mir_app;
    logic [15:0] mir_code;
    logic [15:0] mir_cfg;
    logic [15:0] mir_unit;
    logic [15:0] mir_plen;
    logic [15:0] mir_act;
    logic [31:0] mir_cyc;

    // ------------------------------------------------------------
    // Controller register copies
    // ------------------------------------------------------------
    fbdiag_mirror u_mirror (
        .mclk(mclk),
        .rst(rst),
        .sc_link_status(sc_link_status),
        .sc_app_status(sc_app_status),
        .sc_app_code(sc_app_code),
        .sc_config_mem(sc_config_mem),
        .sc_sync_unit(sc_sync_unit),
        .sc_sync_pulse_len(sc_sync_pulse_len),
        .sc_sync_active(sc_sync_active),
        .sc_sync0_cycle(sc_sync0_cycle),
        .link_layer_status_mirror(mir_link),
        .app_layer_status_mirror(mir_app),
        .app_layer_status_code_mirror(mir_code),
        .config_memory_mirror(mir_cfg),
        .sync_output_unit_mirror(mir_unit),
        .sync_pulse_length_mirror(mir_plen),
        .sync_activation_mirror(mir_act),
        .sync0_cycle_time_mirror(mir_cyc)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] inc16_sat(input logic [15:0] v);
        inc16_sat = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lim);
        clamp16 = (v > {16'h0000, lim}) ? lim : v[15:0];
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic in_op;
    logic enter_op;
    logic fault_cond;

    always_comb begin
        st_d = st_q;
        st_d.rvalid = 1'b0;
        st_d.tick = 1'b0;
        st_d.prev_state = link_state;

        in_op = (link_state == LINK_OP);
        enter_op = in_op && (st_q.prev_state == LINK_SAFEOP);

        // Values that restart on entry to operational.
        if (enter_op) begin
            st_d.lost_ac = '0; // [RULE6]
            st_d.consec = '0; // [RULE7]
            st_d.rx_total = '0; // [RULE10]
        end

        if (in_op) begin
            if (pdo_rx_lost) begin
                st_d.lost_total = st_q.lost_total + 32'h0000_0001; // [RULE5]
                st_d.lost_ac = st_d.lost_ac + 32'sh0000_0001; // [RULE6]
                st_d.consec = inc16_sat(st_d.consec); // [RULE7]
            end else if (pdo_rx_ok) begin
                st_d.consec = '0;
            end
            if (pdo_rx_ok && st_d.rx_total != 32'hffff_ffff) begin
                st_d.rx_total = st_d.rx_total + 32'h0000_0001; // [RULE9]
            end
            if (st_d.consec > st_q.max_consec) begin
                st_d.max_consec = st_d.consec; // [RULE4]
            end
            // A sync and a frame in the same cycle cancel out.
            if (hardware_timed_sync && (sync_pulse != pdo_rx_ok)) begin
                st_d.diff = sync_pulse ? st_q.diff + 32'sh0000_0001
                                       : st_q.diff - 32'sh0000_0001; // [RULE8]
            end
        end

        // Fault is dropped when the drive leaves operation enabled; no new
        // detection can occur in that cycle, since detection needs operation enabled.
        fault_cond = in_op && drive_op_enabled && (st_d.consec > st_q.tol); // [RULE2] [RULE11]
        if (!drive_op_enabled) begin
            st_d.fault = 1'b0; // [RULE11]
        end
        if (fault_cond) begin
            st_d.fault = 1'b1; // [RULE2]
            if (!st_q.fault) begin
                st_d.detail = {DETAIL_CAUSE_MISSED, 8'h00, st_d.consec};
            end
        end

        // Software-timed sync: a microsecond prescaler feeds a period counter.
        if (hardware_timed_sync || st_q.period == 32'h0000_0000) begin
            st_d.us_cnt = '0;
            st_d.tick_cnt = '0;
        end else if (st_q.us_cnt == US_LAST) begin
            st_d.us_cnt = '0;
            if (st_q.tick_cnt >= st_q.period - 32'h0000_0001) begin
                st_d.tick_cnt = '0;
                st_d.tick = 1'b1; // [RULE1]
            end else begin
                st_d.tick_cnt = st_q.tick_cnt + 32'h0000_0001;
            end
        end else begin
            st_d.us_cnt = st_q.us_cnt + 7'h01;
        end

        // Software writes take priority over counting in the same cycle.
        if (par_wr) begin
            unique case (par_addr)
                ADDR_SYNC_CYCLE_PERIOD: begin
                    st_d.period = (par_wdata > MAX_SYNC_CYCLE_PERIOD)
                                  ? MAX_SYNC_CYCLE_PERIOD : par_wdata; // [RULE1]
                end
                ADDR_MISSED_TOLERANCE: begin
                    st_d.tol = clamp16(par_wdata, MAX_MISSED_TOLERANCE); // [RULE2] [RULE3]
                end
                ADDR_MAX_CONSEC_LOSS: begin
                    st_d.max_consec = par_wdata[15:0]; // [RULE19]
                end
                ADDR_LOST_TOTAL: begin
                    st_d.lost_total = par_wdata; // [RULE19]
                end
                ADDR_LOST_TOTAL_AUTOCLR: begin
                    st_d.lost_ac = par_wdata; // [RULE19]
                end
                ADDR_SYNC_FRAME_DIFF: begin
                    st_d.diff = par_wdata; // [RULE19]
                end
                ADDR_RX_TOTAL: begin
                    st_d.rx_total = par_wdata; // [RULE10] [RULE19]
                end
                ADDR_CONSEC_AUTOCLR: begin
                    st_d.consec = par_wdata[15:0]; // [RULE19]
                end
                default: begin
                end
            endcase
        end

        // Reads return the value held before this cycle's updates.
        if (par_rd) begin
            st_d.rvalid = 1'b1;
            unique case (par_addr)
                ADDR_SYNC_CYCLE_PERIOD: st_d.rdata = st_q.period;
                ADDR_LINK_LAYER_STATUS: st_d.rdata = {16'h0000, mir_link}; // [RULE13]
                ADDR_APP_LAYER_STATUS: st_d.rdata = {16'h0000, mir_app}; // [RULE14]
                ADDR_APP_LAYER_CODE: st_d.rdata = {16'h0000, mir_code}; // [RULE12] [RULE15]
                ADDR_CONFIG_MEMORY: st_d.rdata = {16'h0000, mir_cfg}; // [RULE16]
                ADDR_SYNC_OUTPUT_UNIT: st_d.rdata = {16'h0000, mir_unit}; // [RULE17]
                ADDR_SYNC_PULSE_LENGTH: st_d.rdata = {16'h0000, mir_plen}; // [RULE17]
                ADDR_SYNC_ACTIVATION: st_d.rdata = {16'h0000, mir_act}; // [RULE17]
                ADDR_SYNC0_CYCLE_TIME: st_d.rdata = mir_cyc; // [RULE17]
                ADDR_COMM_ERROR_DETAIL: st_d.rdata = st_q.detail;
                ADDR_MISSED_TOLERANCE: st_d.rdata = {16'h0000, st_q.tol};
                ADDR_MAX_CONSEC_LOSS: st_d.rdata = {16'h0000, st_q.max_consec};
                ADDR_LOST_TOTAL: st_d.rdata = st_q.lost_total;
                ADDR_LOST_TOTAL_AUTOCLR: st_d.rdata = st_q.lost_ac;
                ADDR_SYNC_FRAME_DIFF: st_d.rdata = st_q.diff;
                ADDR_RX_TOTAL: st_d.rdata = st_q.rx_total;
                ADDR_CONSEC_AUTOCLR: st_d.rdata = {16'h0000, st_q.consec};
                ADDR_ENTRY_COUNT: st_d.rdata = {24'h000000, DIAG_ENTRY_COUNT}; // [RULE18]
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
            st_q.period <= RST_SYNC_CYCLE_PERIOD;
            st_q.tol <= RST_MISSED_TOLERANCE;
        end else begin
            st_q <= st_d;
        end
    end

    assign par_rdata = st_q.rdata;
    assign par_rvalid = st_q.rvalid;
    assign comm_fault = st_q.fault;
    assign soft_sync_tick = st_q.tick;

endmodule

// ===== tb/fbdiag_top_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checks of the diagnostics block
// ------------------------------------------------------------
module fbdiag_top_asserts
    import fbdiag_pkg::*;
(
    input wire logic mclk, // Drive clock
    input wire logic rst, // Synchronous reset
    input wire logic [10:0] par_addr, // Parameter address
    input wire logic par_rd, // Read strobe
    input wire logic [31:0] par_rdata, // Read data
    input wire logic par_rvalid, // Read data valid
    input wire logic [3:0] link_state, // Link state code
    input wire logic hardware_timed_sync, // Hardware sync selected
    input wire logic drive_op_enabled, // Drive operation-enabled
    input wire logic pdo_rx_lost, // Missed frame pulse
    input wire logic [15:0] sc_app_code, // Controller status code
    input wire logic comm_fault, // Communication fault
    input wire logic soft_sync_tick // Software sync pulse
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // The mirror lags its source by one edge, so only a steady code is compared.
    sequence code_steady;
        !$past(rst) && $stable(sc_app_code);
    endsequence
    sequence code_read;
        par_rd && par_addr == ADDR_APP_LAYER_CODE;
    endsequence
    a_code_mirror_read: assert property ((code_steady and code_read) |=>
        par_rdata == {16'h0000, $past(sc_app_code)}) else $error("status code mirror wrong");
    a_read_answered: assert property (par_rd |=> par_rvalid)
        else $error("read not answered next cycle");
    a_entry_count: assert property (par_rd && par_addr == ADDR_ENTRY_COUNT |=>
        par_rdata == 32'h0000_000f) else $error("entry count not 15");
    a_fault_from_loss: assert property ($rose(comm_fault) |->
        $past(pdo_rx_lost) && $past(link_state) == LINK_OP) else $error("fault without loss");
    a_fault_when_enabled: assert property ($rose(comm_fault) |-> $past(drive_op_enabled))
        else $error("fault raised while not enabled");
    a_fault_drops: assert property (!drive_op_enabled |=> !comm_fault)
        else $error("fault kept while not enabled");
    a_fault_holds: assert property (comm_fault && drive_op_enabled |=> comm_fault)
        else $error("fault dropped early");
    a_tick_soft_only: assert property (hardware_timed_sync [*3] |-> !soft_sync_tick)
        else $error("soft tick under hardware sync");
    a_tick_spacing: assert property (soft_sync_tick |=> !soft_sync_tick [*8])
        else $error("soft ticks too close");
endmodule

bind fbdiag_top fbdiag_top_asserts fbdiag_top_asserts_i (.mclk, .rst, .par_addr, .par_rd,
    .par_rdata, .par_rvalid, .link_state, .hardware_timed_sync, .drive_op_enabled,
    .pdo_rx_lost, .sc_app_code, .comm_fault, .soft_sync_tick);

// ===== tb/fbdiag_master_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Fieldbus master as seen through the slave controller
// ------------------------------------------------------------
module fbdiag_master_model
    import fbdiag_pkg::*;
(
    input wire logic mclk, // Drive clock
    output logic [3:0] link_state, // Link state code
    output logic pdo_rx_ok, // Good frame pulse
    output logic pdo_rx_lost, // Missed frame pulse
    output logic sync_pulse, // Sync pulse
    output logic [15:0] sc_link_status, // Link-layer status
    output logic [15:0] sc_app_status, // App-layer status
    output logic [15:0] sc_app_code, // App-layer status code
    output logic [15:0] sc_config_mem, // Config-memory control
    output logic [15:0] sc_sync_unit, // Sync output unit
    output logic [15:0] sc_sync_pulse_len, // Sync pulse length
    output logic [15:0] sc_sync_active, // Sync activation
    output logic [31:0] sc_sync0_cycle // Sync0 cycle time
);
    // Distinct patterns, so a swapped or truncated mirror shows up.
    assign sc_link_status = 16'ha110;
    assign sc_app_status = 16'ha130;
    assign sc_app_code = 16'ha134;
    assign sc_config_mem = 16'ha500;
    assign sc_sync_unit = 16'ha980;
    assign sc_sync_pulse_len = 16'ha982;
    assign sc_sync_active = 16'ha984;
    assign sc_sync0_cycle = 32'hc9a0_59a3;
    initial begin
        link_state = LINK_INIT;
        {pdo_rx_ok, pdo_rx_lost, sync_pulse} = 3'b000;
    end
    task automatic go(input logic [3:0] s);
        @(negedge mclk);
        link_state = s;
    endtask
    task automatic pulse(input logic ok, input logic lost, input logic sy);
        @(negedge mclk);
        {pdo_rx_ok, pdo_rx_lost, sync_pulse} = {ok, lost, sy};
        @(negedge mclk);
        {pdo_rx_ok, pdo_rx_lost, sync_pulse} = 3'b000;
    endtask
endmodule

// ===== tb/fbdiag_top_bench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register-level bench of the diagnostics block
// ------------------------------------------------------------
module fbdiag_top_bench
    import fbdiag_pkg::*;
;
    logic mclk, rst, par_wr, par_rd, hardware_timed_sync, drive_op_enabled;
    logic pdo_rx_ok, pdo_rx_lost, sync_pulse, par_rvalid, comm_fault, soft_sync_tick;
    logic [10:0] par_addr;
    logic [31:0] par_wdata, par_rdata, sc_sync0_cycle;
    logic [3:0] link_state;
    logic [15:0] sc_link_status, sc_app_status, sc_app_code, sc_config_mem;
    logic [15:0] sc_sync_unit, sc_sync_pulse_len, sc_sync_active;
    int err_count, samples_checked, cycles, gap;

    fbdiag_top fbdiag_top_i (.mclk, .rst, .par_addr, .par_wr, .par_wdata, .par_rd, .par_rdata,
        .par_rvalid, .link_state, .hardware_timed_sync, .drive_op_enabled, .pdo_rx_ok,
        .pdo_rx_lost, .sync_pulse, .sc_link_status, .sc_app_status, .sc_app_code,
        .sc_config_mem, .sc_sync_unit, .sc_sync_pulse_len, .sc_sync_active, .sc_sync0_cycle,
        .comm_fault, .soft_sync_tick);
    fbdiag_master_model fbdiag_master_model_i (.mclk, .link_state, .pdo_rx_ok, .pdo_rx_lost,
        .sync_pulse, .sc_link_status, .sc_app_status, .sc_app_code, .sc_config_mem,
        .sc_sync_unit, .sc_sync_pulse_len, .sc_sync_active, .sc_sync0_cycle);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [10:0] a, input logic [31:0] d);
        @(negedge mclk);
        {par_addr, par_wdata, par_wr} = {a, d, 1'b1};
        @(negedge mclk);
        par_wr = 1'b0;
    endtask
    task automatic rd(input logic [10:0] a, input logic [31:0] exp);
        @(negedge mclk);
        {par_addr, par_rd} = {a, 1'b1};
        @(negedge mclk);
        check(par_rvalid ? par_rdata : ~exp, exp);
        par_rd = 1'b0;
    endtask
    task automatic ev(input logic ok, input logic lost, input logic sy, input int n);
        repeat (n) fbdiag_master_model_i.pulse(ok, lost, sy);
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // A hang would otherwise leave the run without a verdict.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        {rst, par_wr, par_rd, par_addr, par_wdata} = {1'b1, 1'b0, 1'b0, 11'h000, 32'h0};
        {hardware_timed_sync, drive_op_enabled} = 2'b01;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        rd(ADDR_SYNC_CYCLE_PERIOD, 32'h0);
        rd(ADDR_MISSED_TOLERANCE, 32'h1);
        rd(ADDR_MAX_CONSEC_LOSS, 32'h0);
        rd(ADDR_LOST_TOTAL, 32'h0);
        rd(ADDR_RX_TOTAL, 32'h0);
        rd(11'h000, 32'h0);
        rd(ADDR_LINK_LAYER_STATUS, {16'h0, sc_link_status});
        rd(ADDR_APP_LAYER_STATUS, {16'h0, sc_app_status});
        rd(ADDR_CONFIG_MEMORY, {16'h0, sc_config_mem});
        rd(ADDR_SYNC_OUTPUT_UNIT, {16'h0, sc_sync_unit});
        rd(ADDR_SYNC_PULSE_LENGTH, {16'h0, sc_sync_pulse_len});
        rd(ADDR_SYNC_ACTIVATION, {16'h0, sc_sync_active});
        rd(ADDR_SYNC0_CYCLE_TIME, sc_sync0_cycle);
        wr(ADDR_APP_LAYER_CODE, 32'h5555);
        rd(ADDR_APP_LAYER_CODE, {16'h0, sc_app_code});
        wr(ADDR_ENTRY_COUNT, 32'h33);
        rd(ADDR_ENTRY_COUNT, 32'h0f);
        wr(ADDR_MISSED_TOLERANCE, 32'd200);
        rd(ADDR_MISSED_TOLERANCE, 32'h80);
        wr(ADDR_SYNC_CYCLE_PERIOD, 32'd40000);
        rd(ADDR_SYNC_CYCLE_PERIOD, 32'h7d00);
        wr(ADDR_MISSED_TOLERANCE, 32'd5);
        rd(ADDR_MISSED_TOLERANCE, 32'h5);
        wr(ADDR_MISSED_TOLERANCE, 32'd1);
        fbdiag_master_model_i.go(LINK_SAFEOP);
        ev(1'b0, 1'b1, 1'b0, 2);
        ev(1'b1, 1'b0, 1'b0, 1);
        rd(ADDR_LOST_TOTAL, 32'h0);
        rd(ADDR_RX_TOTAL, 32'h0);
        fbdiag_master_model_i.go(LINK_OP);
        ev(1'b0, 1'b1, 1'b0, 1);
        check({31'h0, comm_fault}, 32'h0);
        ev(1'b0, 1'b1, 1'b0, 1);
        check({31'h0, comm_fault}, 32'h1);
        rd(ADDR_MAX_CONSEC_LOSS, 32'h2);
        rd(ADDR_LOST_TOTAL_AUTOCLR, 32'h2);
        rd(ADDR_CONSEC_AUTOCLR, 32'h2);
        rd(ADDR_COMM_ERROR_DETAIL, 32'h0100_0002);
        ev(1'b1, 1'b0, 1'b0, 1);
        rd(ADDR_CONSEC_AUTOCLR, 32'h0);
        rd(ADDR_RX_TOTAL, 32'h1);
        drive_op_enabled = 1'b0;
        @(negedge mclk);
        check({31'h0, comm_fault}, 32'h0);
        ev(1'b0, 1'b1, 1'b0, 3);
        check({31'h0, comm_fault}, 32'h0);
        rd(ADDR_MAX_CONSEC_LOSS, 32'h3);
        fbdiag_master_model_i.go(LINK_SAFEOP);
        fbdiag_master_model_i.go(LINK_OP);
        rd(ADDR_LOST_TOTAL_AUTOCLR, 32'h0);
        rd(ADDR_CONSEC_AUTOCLR, 32'h0);
        rd(ADDR_RX_TOTAL, 32'h0);
        rd(ADDR_LOST_TOTAL, 32'h5);
        rd(ADDR_MAX_CONSEC_LOSS, 32'h3);
        wr(ADDR_RX_TOTAL, 32'hffff_fffe);
        ev(1'b1, 1'b0, 1'b0, 3);
        rd(ADDR_RX_TOTAL, 32'hffff_ffff);
        wr(ADDR_LOST_TOTAL, 32'h10);
        ev(1'b0, 1'b1, 1'b0, 1);
        rd(ADDR_LOST_TOTAL, 32'h11);
        wr(ADDR_SYNC_FRAME_DIFF, 32'h0);
        hardware_timed_sync = 1'b1;
        ev(1'b0, 1'b0, 1'b1, 3);
        ev(1'b1, 1'b0, 1'b0, 1);
        rd(ADDR_SYNC_FRAME_DIFF, 32'h2);
        hardware_timed_sync = 1'b0;
        ev(1'b0, 1'b0, 1'b1, 2);
        rd(ADDR_SYNC_FRAME_DIFF, 32'h2);
        wr(ADDR_SYNC_FRAME_DIFF, 32'hffff_fffe);
        hardware_timed_sync = 1'b1;
        ev(1'b0, 1'b0, 1'b1, 1);
        rd(ADDR_SYNC_FRAME_DIFF, 32'hffff_ffff);
        fbdiag_master_model_i.go(LINK_PREOP);
        ev(1'b0, 1'b0, 1'b1, 1);
        rd(ADDR_SYNC_FRAME_DIFF, 32'hffff_ffff);
        hardware_timed_sync = 1'b0;
        wr(ADDR_SYNC_CYCLE_PERIOD, 32'h1);
        gap = 0;
        while (soft_sync_tick !== 1'b1 && gap < 400) begin
            @(negedge mclk);
            gap++;
        end
        gap = 0;
        do begin
            @(negedge mclk);
            gap++;
        end while (soft_sync_tick !== 1'b1 && gap < 400);
        check(gap, CYC_PER_US);
        tally_and_finish();
    end
endmodule
